// ---- logic/sram_io_pkg.sv ----
// Constants shared by the synchronous SRAM data I/O block.
// Assumes a single 25 MHz core clock; test clock is sampled as a plain input.
package sram_io_pkg;
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SLEEP_CYCLES    = 2;
    localparam logic [1:0]  SLEEP_CNT_RST   = 2'h0;
    localparam logic [1:0]  BURST_CNT_RST   = 2'h0;
    localparam logic        STRAP_RST       = 1'h1;
    localparam int          DATA_W_DEF      = 32;
    localparam int          BYTES_DEF       = 4;
    localparam int          ADDR_W_DEF      = 6;
    localparam int          BUF_DEPTH       = 2;
endpackage

// ---- logic/sync_sram_data_io_control.sv ----
// Data I/O, sleep and burst-order logic of a flow-through burst SRAM.
// Assumes controller-side inputs are synchronous to core_clk; the pin level is
// resolved outside from dq_oe/parity_oe. Test clock is sampled on core_clk.
`timescale 1ns/1ps

// Behaviour
// - A high sleep_request puts the device to sleep while memory contents stay intact.
// - Data lines acting as inputs are captured on the rising clock edge.
// - A read drives the word addressed at the preceding edge, with no extra stage.
// - Data and parity drive only while output enable (active low) is low.
// - Outputs float during write data, the first clock after deselect, and when deselected.
// - Parity lines behave like data lines and are written per byte write select.
// - Strap low gives linear burst order, high or floating gives interleaved.
// - The scan serial output changes on falling test clock edges.
// - Scan input and mode select are sampled on rising test clock edges.
// - Sleep entry and exit take two clocks; controller deselects before sleeping.
module sync_sram_data_io_control
    import sram_io_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int BYTES  = BYTES_DEF,
    parameter int ADDR_W = ADDR_W_DEF
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              adv_load_n,
    input  wire logic              chip_select_lo_a,
    input  wire logic              chip_select_hi,
    input  wire logic              chip_select_lo_b,
    input  wire logic              write_en_n,
    input  wire logic [BYTES-1:0]  byte_write_select_n,
    input  wire logic              out_en_n,
    input  wire logic              sleep_request,
    input  wire logic              burst_order,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    input  wire logic [BYTES-1:0]  parity_in,
    output logic      [BYTES-1:0]  parity_out,
    output logic                   parity_oe,
    output logic                   asleep,
    input  wire logic              test_clk,
    input  wire logic              test_data_in,
    input  wire logic              test_mode_sel,
    output logic                   test_data_out,
    output logic                   test_data_oe,
    output logic                   wr_ready
);

    localparam int BW = DATA_W / BYTES;

    // ----------------------------------------------------------------
    // Sleep control
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {AWAKE, ENTERING, SLEEPING, LEAVING} sleep_t;
    sleep_t     sleep_q;
    sleep_t     sleep_d;
    logic [1:0] sleep_cnt_q;
    logic       sleep_meta_q;
    logic       sleep_sync_q;
    wire        sleep_done = (sleep_cnt_q == 2'(SLEEP_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
        end else begin
            sleep_meta_q <= sleep_request;
            sleep_sync_q <= sleep_meta_q;
        end
    end

    always_comb begin
        sleep_d = sleep_q;
        case (sleep_q)
            AWAKE:    if (sleep_sync_q) sleep_d = ENTERING;
            ENTERING: if (sleep_done) sleep_d = SLEEPING;
            SLEEPING: if (!sleep_sync_q) sleep_d = LEAVING;
            LEAVING:  if (sleep_done) sleep_d = AWAKE;
            default:  sleep_d = AWAKE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_q     <= AWAKE;
            sleep_cnt_q <= SLEEP_CNT_RST;
        end else begin
            sleep_q     <= sleep_d;
            sleep_cnt_q <= (sleep_d != sleep_q || sleep_q == AWAKE || sleep_q == SLEEPING) ? SLEEP_CNT_RST
                                                                                          : sleep_cnt_q + 2'h1;
        end
    end

    // Array stays powered in sleep; only access logic is frozen
    assign asleep = (sleep_q != AWAKE);

    // ----------------------------------------------------------------
    // Access pipeline and burst counter
    // ----------------------------------------------------------------
    function automatic logic [1:0] burst_next(input logic [1:0] base, input logic [1:0] step, input logic lin);
        burst_next = lin ? base + step : base ^ step;
    endfunction

    wire selected  = !chip_select_lo_a && chip_select_hi && !chip_select_lo_b;
    wire load      = !adv_load_n && !asleep;
    logic              strap_q;
    logic [ADDR_W-1:0] base_q;
    logic [1:0]        step_q;
    logic              active_q;
    logic              wr_q;
    logic              was_desel_q;
    logic [ADDR_W-1:0] acc_addr_q;

    // Strap caught after reset release, never under reset
    logic strap_taken_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_q       <= STRAP_RST;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_q       <= burst_order;
            strap_taken_q <= 1'b1;
        end
    end

    wire [1:0] next_low = burst_next(base_q[1:0], step_q + 2'h1, !strap_q);
    wire       adv      = adv_load_n && active_q && !asleep;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_q      <= '0;
            step_q      <= BURST_CNT_RST;
            active_q    <= 1'b0;
            wr_q        <= 1'b0;
            was_desel_q <= 1'b1;
            acc_addr_q  <= '0;
        end else if (load) begin
            base_q      <= addr;
            step_q      <= BURST_CNT_RST;
            active_q    <= selected;
            wr_q        <= !write_en_n;
            was_desel_q <= !active_q;
            acc_addr_q  <= addr;
        end else if (adv) begin
            step_q      <= step_q + 2'h1;
            was_desel_q <= 1'b0;
            acc_addr_q  <= {base_q[ADDR_W-1:2], next_low};
        end else begin
            active_q    <= 1'b0; // pending access dropped on sleep
            was_desel_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer (two entries) and array
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]       mem [2**ADDR_W];
    logic [BYTES-1:0]        par_mem [2**ADDR_W];
    logic [DATA_W-1:0]       wb_data_q [BUF_DEPTH];
    logic [BYTES-1:0]        wb_par_q  [BUF_DEPTH];
    logic [BYTES-1:0]        wb_be_q   [BUF_DEPTH];
    logic [ADDR_W-1:0]       wb_addr_q [BUF_DEPTH];
    logic [1:0]              wb_cnt_q;
    logic                    wb_rd_q;
    logic                    wb_wr_q;

    wire wb_push  = active_q && wr_q && !asleep;
    wire wb_valid = (wb_cnt_q != 2'h0);
    wire wb_pop   = wb_valid && !asleep; // array drain stalls in sleep
    assign wr_ready = (wb_cnt_q != 2'(BUF_DEPTH));

    always_ff @(posedge core_clk) begin
        if (wb_push && wr_ready) begin
            wb_data_q[wb_wr_q] <= dq_in;
            wb_par_q[wb_wr_q]  <= parity_in;
            wb_be_q[wb_wr_q]   <= ~byte_write_select_n;
            wb_addr_q[wb_wr_q] <= acc_addr_q;
        end
        if (wb_pop) begin
            for (int b = 0; b < BYTES; b++) begin
                if (wb_be_q[wb_rd_q][b]) begin
                    mem[wb_addr_q[wb_rd_q]][b*BW +: BW] <= wb_data_q[wb_rd_q][b*BW +: BW];
                    par_mem[wb_addr_q[wb_rd_q]][b]      <= wb_par_q[wb_rd_q][b];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_cnt_q <= 2'h0;
            wb_rd_q  <= 1'b0;
            wb_wr_q  <= 1'b0;
        end else begin
            wb_cnt_q <= wb_cnt_q + 2'(wb_push && wr_ready) - 2'(wb_pop);
            if (wb_push && wr_ready) wb_wr_q <= !wb_wr_q;
            if (wb_pop) wb_rd_q <= !wb_rd_q;
        end
    end

    // ----------------------------------------------------------------
    // Read path, flow-through
    // ----------------------------------------------------------------
    // Pending write to same word is forwarded so read sees newest data
    logic hit0;
    logic hit1;
    assign hit0 = wb_cnt_q != 2'h0 && wb_addr_q[wb_rd_q] == acc_addr_q;
    assign hit1 = wb_cnt_q == 2'h2 && wb_addr_q[!wb_rd_q] == acc_addr_q;

    always_comb begin
        dq_out     = mem[acc_addr_q];
        parity_out = par_mem[acc_addr_q];
        for (int k = 0; k < 2; k++) begin
            if ((k == 0 && hit0) || (k == 1 && hit1)) begin
                for (int b = 0; b < BYTES; b++) begin
                    if (wb_be_q[k == 0 ? wb_rd_q : !wb_rd_q][b]) begin
                        dq_out[b*BW +: BW] = wb_data_q[k == 0 ? wb_rd_q : !wb_rd_q][b*BW +: BW];
                        parity_out[b]      = wb_par_q[k == 0 ? wb_rd_q : !wb_rd_q][b];
                    end
                end
            end
        end
    end

    wire drive = active_q && !wr_q && !was_desel_q && !asleep && !out_en_n;
    assign dq_oe     = drive;
    assign parity_oe = drive;

    // ----------------------------------------------------------------
    // Scan serial pins
    // ----------------------------------------------------------------
    logic tck_q;
    logic tdi_q;
    logic tms_q;
    logic tdo_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tck_q <= 1'b0;
            tdi_q <= 1'b0;
            tms_q <= 1'b1;
            tdo_q <= 1'b0;
        end else begin
            tck_q <= test_clk;
            if (test_clk && !tck_q) begin
                tdi_q <= test_data_in;
                tms_q <= test_mode_sel;
            end
            if (!test_clk && tck_q) tdo_q <= tdi_q;
        end
    end
    assign test_data_out = tdo_q;
    assign test_data_oe  = !tms_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_oe_blocks_drive: assert property (@(posedge core_clk) disable iff (!rst_b)
        out_en_n |-> !dq_oe && !parity_oe) else $error("drive while oe high");
    a_write_floats: assert property (@(posedge core_clk) disable iff (!rst_b)
        (active_q && wr_q) |-> !dq_oe) else $error("drive during write");
    a_desel_floats: assert property (@(posedge core_clk) disable iff (!rst_b)
        (load && !selected) |=> !dq_oe) else $error("drive after deselect");
    a_sleep_floats: assert property (@(posedge core_clk) disable iff (!rst_b)
        asleep |-> !dq_oe) else $error("drive while asleep");
    a_sleep_entry: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sleep_q == AWAKE && sleep_sync_q) |=> sleep_q == ENTERING ##2 sleep_q == SLEEPING)
        else $error("sleep entry not two clocks");
    a_sleep_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sleep_q == SLEEPING && sleep_sync_q) |=> asleep) else $error("left sleep early");
    a_tdo_falling: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(tdo_q) |-> $past(tck_q) && !$past(test_clk)) else $error("tdo moved off fall");
    a_tdi_rising: assert property (@(posedge core_clk) disable iff (!rst_b)
        (test_clk && !tck_q) |=> tdi_q == $past(test_data_in)) else $error("tdi not sampled");
    a_wr_capture: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wb_push && wr_ready) |=> wb_data_q[$past(wb_wr_q)] == $past(dq_in)) else $error("write lost");
    a_burst_linear: assert property (@(posedge core_clk) disable iff (!rst_b)
        (adv && !strap_q) |=> acc_addr_q[1:0] == $past(base_q[1:0]) + $past(step_q) + 2'h1)
        else $error("linear order wrong");
    c_read_drive: cover property (@(posedge core_clk) dq_oe);
    c_write_full: cover property (@(posedge core_clk) !wr_ready);
    c_sleep_cycle: cover property (@(posedge core_clk) sleep_q == LEAVING ##2 sleep_q == AWAKE);

endmodule // sync_sram_data_io_control

// ---- testbench/sram_ctrl_model.sv ----
// Controller-side model of the shared data and parity bus.
// Assumes the bench says when write data is to be driven.
`timescale 1ns/1ps
module sram_ctrl_model (
    input  wire logic        core_clk,
    input  wire logic        drv_en,
    input  wire logic [35:0] drv_word,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe,
    input  wire logic [3:0]  parity_out,
    input  wire logic        parity_oe,
    output logic      [31:0] dq_in,
    output logic      [3:0]  parity_in,
    output logic             clash
);
    logic [35:0] last_q = '0;
    // Released bus shows the inverse of its last level, so a held value never passes
    assign dq_in     = dq_oe ? dq_out : (drv_en ? drv_word[31:0] : ~last_q[31:0]);
    assign parity_in = parity_oe ? parity_out : (drv_en ? drv_word[35:32] : ~last_q[35:32]);
    assign clash     = drv_en & (dq_oe | parity_oe);
    always @(posedge core_clk) begin
        last_q <= {parity_in, dq_in};
    end
endmodule // sram_ctrl_model

// ---- testbench/sync_sram_data_io_control_tb.sv ----
// Self-checking bench for the SRAM data I/O block.
// Assumes the controller model resolves the shared pins.
`timescale 1ns/1ps
module sync_sram_data_io_control_tb;
    import sram_io_pkg::*;
    logic        core_clk = 0, rst_b = 0, adv_load_n = 0, cs = 0, write_en_n = 1, out_en_n = 0;
    logic        sleep_request = 0, burst_order = 1, test_clk = 0, test_data_in = 0, test_mode_sel = 0;
    logic        drv_en = 0, dq_oe, parity_oe, asleep, test_data_out, test_data_oe, wr_ready, clash;
    logic [5:0]  addr = '0;
    logic [3:0]  byte_write_select_n = '1, parity_in, parity_out;
    logic [31:0] dq_in, dq_out;
    logic [35:0] drv_word = '0, mem [64];
    logic [15:0] lfsr_q = 16'h55cb;
    int          n_errors = 0, checks = 0;
    always #20 core_clk = ~core_clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic cmd(input logic ld, input logic sel, input logic wr, input logic [5:0] a, input logic [3:0] be);
        @(posedge core_clk);
        adv_load_n <= !ld;
        cs <= sel;
        write_en_n <= !wr;
        addr <= a;
        byte_write_select_n <= be;
    endtask
    task automatic wait_asleep(input logic lvl);
        int k;
        for (k = 0; k < 8 && asleep !== lvl; k++) @(negedge core_clk);
        chk(k < 8, "sleep handshake");
        if (k >= 8) print_verdict();
    endtask
    // ----------------------------------------
    // Transfers
    // ----------------------------------------
    task automatic wr_word(input logic [5:0] a, input logic [3:0] be);
        logic [35:0] w;
        w = {lfsr_q[3:0], lfsr_q, ~lfsr_q};
        lfsr_q = lfsr(lfsr_q);
        @(negedge core_clk);
        chk(wr_ready === 1'b1, "write buffer full");
        cmd(1, 1, 1, a, be);
        out_en_n <= 1'b1;
        cmd(1, 0, 0, a, be);
        drv_en <= 1'b1;
        drv_word <= w;
        @(negedge core_clk);
        chk(dq_oe === 1'b0 && parity_oe === 1'b0, "drive in write data cycle");
        cmd(1, 0, 0, a, 4'hf);
        drv_en <= 1'b0;
        for (int b = 0; b < 4; b++) if (!be[b]) begin
            mem[a][8*b+:8] = w[8*b+:8];
            mem[a][32+b] = w[32+b];
        end
    endtask
    task automatic rd_stream(input logic oe_n, input int n);
        logic [5:0] a, prev;
        out_en_n <= oe_n;
        for (int i = 0; i <= n; i++) begin
            a = i[5:0];
            cmd(1, i < n, 0, a, 4'hf);
            @(negedge core_clk);
            if (i > 0) begin
                chk(dq_out === mem[prev][31:0] && parity_out === mem[prev][35:32], "read data");
                chk(dq_oe === (i > 1 && !oe_n) && parity_oe === dq_oe, "output enable");
            end
            prev = a;
        end
    endtask
    sram_ctrl_model i_ctrl (.core_clk(core_clk), .drv_en(drv_en), .drv_word(drv_word), .dq_out(dq_out),
        .dq_oe(dq_oe), .parity_out(parity_out), .parity_oe(parity_oe), .dq_in(dq_in), .parity_in(parity_in),
        .clash(clash));
    sync_sram_data_io_control i_dut (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .adv_load_n(adv_load_n),
        .chip_select_lo_a(!cs), .chip_select_hi(cs), .chip_select_lo_b(!cs), .write_en_n(write_en_n),
        .byte_write_select_n(byte_write_select_n), .out_en_n(out_en_n), .sleep_request(sleep_request),
        .burst_order(burst_order), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .parity_in(parity_in),
        .parity_out(parity_out), .parity_oe(parity_oe), .asleep(asleep), .test_clk(test_clk),
        .test_data_in(test_data_in), .test_mode_sel(test_mode_sel), .test_data_out(test_data_out),
        .test_data_oe(test_data_oe), .wr_ready(wr_ready));
    always @(negedge core_clk) if (clash === 1'b1) chk(1'b0, "bus clash");
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int p = 0; p < 2; p++) begin
            @(posedge core_clk);
            rst_b <= 1'b0;
            burst_order <= p[0];
            repeat (16) @(posedge core_clk);
            chk(dq_oe === 1'b0 && asleep === 1'b0 && wr_ready === 1'b1 && test_data_out === 1'b0
                && test_data_oe === 1'b0, "reset outputs");
            rst_b <= 1'b1;
            for (int a = 0; a < 8; a++) wr_word(a[5:0], 4'h0);
            wr_word(6'h3, 4'ha);
            rd_stream(1'b0, 8);
            cmd(1, 1, 0, 6'h1, 4'hf);
            cmd(0, 0, 0, 6'h0, 4'hf);
            cmd(1, 0, 0, 6'h0, 4'hf);
            @(negedge core_clk);
            chk(dq_out === mem[p ? 0 : 2][31:0], "burst order");
            $display("strap pass %0d done", p);
        end
        rd_stream(1'b1, 4);
        $display("output enable test done");
        cmd(1, 0, 0, 6'h0, 4'hf);
        sleep_request <= 1'b1;
        out_en_n <= 1'b0;
        wait_asleep(1'b1);
        repeat (3) begin
            @(negedge core_clk);
            chk(dq_oe === 1'b0 && parity_oe === 1'b0, "drive while asleep");
        end
        @(posedge core_clk);
        sleep_request <= 1'b0;
        wait_asleep(1'b0);
        rd_stream(1'b0, 8);
        $display("sleep test done");
        @(posedge core_clk);
        test_mode_sel <= lfsr_q[0];
        test_data_in <= lfsr_q[1];
        test_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk(test_data_oe === !test_mode_sel, "scan enable");
        @(posedge core_clk);
        test_clk <= 1'b0;
        test_data_in <= ~lfsr_q[1];
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(test_data_out === lfsr_q[1], "scan output");
        $display("scan pin test done");
        print_verdict();
    end
endmodule // sync_sram_data_io_control_tb
